/* File: hw/pd8_sync.sv */
// package of shared constants and the two-flop input synchroniser
package pd8_pkg;
  // ************************************************************
  // counter geometry
  // ************************************************************
  localparam int          PD8_CNT_W    = 8;
  localparam logic [7:0]  PD8_CNT_MAX  = 8'hff;  // clear value, also wrap target
  localparam logic [7:0]  PD8_CNT_ZERO = 8'h00;
  localparam logic [7:0]  PD8_CNT_ONE  = 8'h01;

  // ************************************************************
  // layout of the synchronised pin bundle
  // ************************************************************
  localparam int          PD8_SYNC_W   = 12;
  localparam int          PD8_B_PRE_LO = 0;      // preset word occupies bits 7..0
  localparam int          PD8_B_PRE_HI = 7;
  localparam int          PD8_B_TE     = 8;
  localparam int          PD8_B_PE     = 9;
  localparam int          PD8_B_PL     = 10;
  localparam int          PD8_B_MR     = 11;
  // every control is active low, so the idle bundle is all ones
  localparam logic [11:0] PD8_SYNC_RST = 12'hfff;
endpackage

`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// two-flop synchroniser for pins from outside the clock domain
// ************************************************************
module pd8_sync
  import pd8_pkg::*;
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  srst_in,
  input  wire logic [PD8_SYNC_W-1:0] async_in,
  output var  logic [PD8_SYNC_W-1:0] sync_out
);

  logic [PD8_SYNC_W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      meta_q   <= PD8_SYNC_RST;
      sync_out <= PD8_SYNC_RST;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* File: hw/pd8_down_counter.sv */
// 8-bit presettable down counter with active-low controls and zero flag
`timescale 1ns/1ps
`default_nettype none

module pd8_down_counter
  import pd8_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 srst_in,
  input  wire logic                 count_clock_in,
  input  wire logic                 master_clear_n_in,
  input  wire logic                 async_load_n_in,
  input  wire logic                 sync_load_n_in,
  input  wire logic                 count_enable_n_in,
  input  wire logic [PD8_CNT_W-1:0] preset_word_in,
  output var  logic [PD8_CNT_W-1:0] count_out,
  output var  logic                 zero_flag_n_out
);

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  // reset levels of the local flops: the count pin idles low, the flag high
  localparam logic PD8_CLK_IDLE  = 1'b0;
  localparam logic PD8_FLAG_IDLE = 1'b1;

  logic [PD8_SYNC_W-1:0] pins_s;
  logic [PD8_CNT_W-1:0]  preset_s;
  logic                  clear_n_s;
  logic                  aload_n_s;
  logic                  sload_n_s;
  logic                  enable_n_s;
  logic                  clk_s;
  logic                  clk_prev_q;
  logic                  clk_rise;
  logic [PD8_CNT_W-1:0]  cnt_d;

  // count_clock is sampled like any other pin; it must run well below ref_clk_in
  pd8_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .async_in   ({master_clear_n_in, async_load_n_in, sync_load_n_in,
                  count_enable_n_in, preset_word_in}),
    .sync_out   (pins_s)
  );

  // unpack the bundle; preset keeps its bit order, bit 7 most significant
  assign preset_s   = pins_s[PD8_B_PRE_HI:PD8_B_PRE_LO];
  assign enable_n_s = pins_s[PD8_B_TE];
  assign sload_n_s  = pins_s[PD8_B_PE];
  assign aload_n_s  = pins_s[PD8_B_PL];
  assign clear_n_s  = pins_s[PD8_B_MR];

  // ************************************************************
  // count_clock edge detection
  // ************************************************************
  // a separate flop so that the synchroniser flops stay untouched
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      clk_prev_q <= PD8_CLK_IDLE;
    end else begin
      clk_prev_q <= count_clock_in;
    end
  end

  // edge seen on the delayed copy keeps it aligned with the other pins
  logic clk_meta_q;
  logic clk_sync_q;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      clk_meta_q <= PD8_CLK_IDLE;
      clk_sync_q <= PD8_CLK_IDLE;
    end else begin
      clk_meta_q <= clk_prev_q;
      clk_sync_q <= clk_meta_q;
    end
  end
  assign clk_s = clk_meta_q;
  // count_clock must stay high and low for one ref cycle each to be seen
  assign clk_rise = clk_s & ~clk_sync_q;

  // ************************************************************
  // next count, in priority order
  // ************************************************************
  // the asynchronous controls act as levels on every ref clock, so they
  // need no count_clock edge; the trade is a two-cycle pin latency
  always_comb begin
    cnt_d = count_out;
    if (!clear_n_s) begin
      cnt_d = PD8_CNT_MAX;
    end else if (!aload_n_s) begin
      cnt_d = preset_s;
    end else if (clk_rise) begin
      if (!sload_n_s) begin
        cnt_d = preset_s;
      end else if (!enable_n_s) begin
        cnt_d = count_out - PD8_CNT_ONE;
      end
    end
  end

  // ************************************************************
  // count and zero flag registers
  // ************************************************************
  // holding when disabled falls out of cnt_d defaulting to the count
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      count_out <= PD8_CNT_MAX;
    end else begin
      count_out <= cnt_d;
    end
  end

  // flag decoded from the next count so it lines up with count_out;
  // it stays low until the count leaves zero or enable_n_s goes high
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      zero_flag_n_out <= PD8_FLAG_IDLE;
    end else begin
      zero_flag_n_out <= ~((cnt_d == PD8_CNT_ZERO) & ~enable_n_s);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  // one clock domain, so one default clocking and disable serve every check
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  // keeps $past away from the reset-time samples on the first live edge
  logic past_ok_q;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      past_ok_q <= 1'b0;
    end else begin
      past_ok_q <= 1'b1;
    end
  end

  a_clear_to_max: assert property (
    !clear_n_s |=> count_out == PD8_CNT_MAX)
    else $error("clear did not give maximum count");

  a_clear_over_load: assert property (
    (!clear_n_s && !aload_n_s && !sload_n_s && clk_rise) |=> count_out == PD8_CNT_MAX)
    else $error("clear lost priority");

  a_async_load_now: assert property (
    (clear_n_s && !aload_n_s) |=> count_out == $past(preset_s))
    else $error("async load did not take preset");

  a_sync_load_edge: assert property (
    (clear_n_s && aload_n_s && !sload_n_s && clk_rise) |=> count_out == $past(preset_s))
    else $error("sync load did not take preset");

  a_count_step: assert property (
    (clear_n_s && aload_n_s && sload_n_s && !enable_n_s && clk_rise
     && count_out != PD8_CNT_ZERO) |=> count_out == $past(count_out) - PD8_CNT_ONE)
    else $error("count did not step down by one");

  a_wrap_max: assert property (
    (clear_n_s && aload_n_s && sload_n_s && !enable_n_s && clk_rise
     && count_out == PD8_CNT_ZERO) |=> count_out == PD8_CNT_MAX)
    else $error("count did not wrap to maximum");

  a_hold_idle: assert property (
    (clear_n_s && aload_n_s && (!clk_rise || (sload_n_s && enable_n_s)))
    |=> $stable(count_out))
    else $error("count changed while idle");

  a_resume_held: assert property (
    (past_ok_q && $rose(aload_n_s) && clear_n_s && !clk_rise) |=> $stable(count_out))
    else $error("count moved on load release");

  a_zero_flag: assert property (
    past_ok_q |-> zero_flag_n_out ==
      !(count_out == PD8_CNT_ZERO && !$past(enable_n_s)))
    else $error("zero flag does not match count and enable");

  a_flag_follows: assert property (
    (count_out == PD8_CNT_ZERO && clear_n_s && aload_n_s && !clk_rise && $rose(enable_n_s))
    |=> zero_flag_n_out)
    else $error("zero flag ignored enable release");

  // any nonzero count must leave the flag high, whatever the enable does
  a_flag_nonzero: assert property (
    count_out != PD8_CNT_ZERO |-> zero_flag_n_out)
    else $error("zero flag low on a nonzero count");

  // a high enable must block a count_clock rise that no load accompanies
  a_enable_freeze: assert property (
    (clear_n_s && aload_n_s && sload_n_s && enable_n_s && clk_rise)
    |=> $stable(count_out))
    else $error("count moved with enable high");

  // async load must win over a counting rise; a lost race shows as the old count - 1
  a_aload_over_count: assert property (
    (clear_n_s && !aload_n_s && !enable_n_s && clk_rise)
    |=> count_out == $past(preset_s))
    else $error("count beat async load");

  c_full_wrap: cover property (
    count_out == PD8_CNT_ZERO && clk_rise && !enable_n_s ##1 count_out == PD8_CNT_MAX);
  c_flag_low: cover property (!zero_flag_n_out);
  c_async_load: cover property (clear_n_s && !aload_n_s ##1 aload_n_s);
  c_sync_load: cover property (clear_n_s && aload_n_s && !sload_n_s && clk_rise);
  // the flag must be seen low on one cycle and back high on the next; the cover records this but checks no cause
  c_flag_release: cover property (!zero_flag_n_out ##1 zero_flag_n_out);

endmodule

`default_nettype wire

/* File: bench/pd8_far_model.sv */
// far-side model: surrounding logic that makes count_clock pulses
`timescale 1ns/1ps
`default_nettype none

module pd8_far_model (
  input  wire logic ref_clk_in,
  input  wire logic srst_in,
  input  wire logic pulse_req_in,
  input  wire logic cascade_in,
  output var  logic count_clock_out,
  output var  logic busy_out,
  output var  logic stage_flag_n_out
);
  logic [2:0] phase_q;
  logic [1:0] stage_q;

  // ************************************************************
  // pulse maker
  // ************************************************************
  // each phase is 4 ref cycles, above the 1-cycle floor of the sync path;
  // the pin stands low between pulses, as a gated clock would
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      busy_out <= 1'b0;
      phase_q  <= 3'h0;
    end else if (busy_out) begin
      phase_q <= phase_q + 3'h1;
      if (phase_q == 3'h7) busy_out <= 1'b0;
    end else if (pulse_req_in) begin
      busy_out <= 1'b1;
      phase_q  <= 3'h0;
    end
  end
  assign count_clock_out = busy_out && !phase_q[2];

  // ************************************************************
  // upstream cascade stage
  // ************************************************************
  // a divide-by-four whose zero flag gates the next stage; it moves only
  // at the end of a pulse, so the enable never races a count_clock rise
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !cascade_in) begin
      stage_q <= 2'h3;
    end else if (busy_out && phase_q == 3'h7) begin
      stage_q <= stage_q - 2'h1;
    end
  end
  assign stage_flag_n_out = (stage_q != 2'h0);
endmodule
`default_nettype wire

/* File: bench/pd8_testbench.sv */
// self-checking bench for the presettable down counter
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pd8_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       srst_in    = 1'b1;
  logic       req        = 1'b0;
  logic       cclk;
  logic       busy;
  logic       cas        = 1'b0;
  logic       stage_n;
  logic       mr_n       = 1'b1;
  logic       al_n       = 1'b1;
  logic       sl_n       = 1'b1;
  logic       en_n       = 1'b1;
  logic [7:0] pre        = 8'h00;
  logic [7:0] count_out;
  logic       zero_flag_n_out;
  int         err_count   = 0;
  int         check_count = 0;

  always #2.5 ref_clk_in = ~ref_clk_in;

  pd8_far_model far_u (
    .ref_clk_in       (ref_clk_in),
    .srst_in          (srst_in),
    .pulse_req_in     (req),
    .cascade_in       (cas),
    .count_clock_out  (cclk),
    .busy_out         (busy),
    .stage_flag_n_out (stage_n)
  );

  // in cascade mode the upstream stage's zero flag is this stage's enable
  pd8_down_counter dut_u (
    .ref_clk_in        (ref_clk_in),
    .srst_in           (srst_in),
    .count_clock_in    (cclk),
    .master_clear_n_in (mr_n),
    .async_load_n_in   (al_n),
    .sync_load_n_in    (sl_n),
    .count_enable_n_in (cas ? stage_n : en_n),
    .preset_word_in    (pre),
    .count_out         (count_out),
    .zero_flag_n_out   (zero_flag_n_out)
  );

  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // controls settle 6 cycles, past the synchroniser latency
  task automatic ctl(input logic mr, al, sl, en, input logic [7:0] p);
    @(posedge ref_clk_in);
    mr_n <= mr;
    al_n <= al;
    sl_n <= sl;
    en_n <= en;
    pre  <= p;
    repeat (6) @(posedge ref_clk_in);
  endtask

  // one pulse; busy is only visible one edge after the model took req
  task automatic pulse();
    int i;
    @(posedge ref_clk_in);
    req <= 1'b1;
    @(posedge ref_clk_in);
    req <= 1'b0;
    @(posedge ref_clk_in);
    if (!busy) begin
      err_count++;
      $display("CHECK FAILED %0t pulse never started", $time);
    end
    for (i = 0; i < 20 && busy; i++) begin
      @(posedge ref_clk_in);
    end
    if (busy) begin
      err_count++;
      $display("CHECK FAILED %0t pulse timeout", $time);
      results();
    end
    repeat (2) @(posedge ref_clk_in);
  endtask

  task automatic check(input logic [7:0] c, input logic f);
    check_count++;
    if (count_out !== c || zero_flag_n_out !== f) begin
      err_count++;
      $display("CHECK FAILED %0t count %h flag %b want %h %b", $time, count_out,
               zero_flag_n_out, c, f);
    end
  endtask

  // sync load ignores enable, then count down to zero and wrap
  task automatic t_count();
    ctl(1, 1, 0, 1, 8'h02);
    pulse();
    check(8'h02, 1'b1);
    ctl(1, 1, 1, 0, 8'h00);
    pulse();
    check(8'h01, 1'b1);
    pulse();
    check(8'h00, 1'b0);
    ctl(1, 1, 1, 1, 8'h00);
    check(8'h00, 1'b1);
    pulse();
    check(8'h00, 1'b1);
    ctl(1, 1, 1, 0, 8'h00);
    check(8'h00, 1'b0);
    pulse();
    check(8'hff, 1'b1);
  endtask

  // async load beats the clock and follows the preset; resume after release
  task automatic t_async();
    ctl(1, 0, 0, 0, 8'ha5);
    check(8'ha5, 1'b1);
    pulse();
    check(8'ha5, 1'b1);
    ctl(1, 1, 1, 0, 8'h3c);
    pulse();
    check(8'ha4, 1'b1);
    ctl(1, 0, 1, 0, 8'h01);
    check(8'h01, 1'b1);
    ctl(1, 0, 1, 0, 8'h80);
    check(8'h80, 1'b1);
  endtask

  // clear beats async load; a full cycle is 256 pulses
  task automatic t_clear();
    ctl(0, 0, 0, 0, 8'h12);
    check(8'hff, 1'b1);
    pulse();
    check(8'hff, 1'b1);
    ctl(1, 1, 1, 0, 8'h12);
    pulse();
    check(8'hfe, 1'b1);
    repeat (255) pulse();
    check(8'hff, 1'b1);
  endtask

  // cascade: an upstream divide-by-four stage gates this stage's enable,
  // so only every fourth pulse moves the count
  task automatic t_cascade();
    ctl(1, 0, 1, 1, 8'h10);
    ctl(1, 1, 1, 1, 8'h10);
    cas <= 1'b1;
    repeat (3) pulse();
    check(8'h10, 1'b1);
    pulse();
    check(8'h0f, 1'b1);
    repeat (4) pulse();
    check(8'h0e, 1'b1);
    @(posedge ref_clk_in);
    cas <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    check(PD8_CNT_MAX, 1'b1);
    t_count();
    t_async();
    t_clear();
    t_cascade();
    results();
  end
endmodule
`default_nettype wire
